// *** verilog/jsp_pkg.sv ***
// Shared constants and types for the dual-protocol debug port and its probe.
// Assumes both ends run on a 25 MHz system clock; the link clock is made by the probe.
package jsp_pkg;
	localparam int NPIN = 5;
	localparam int PIN_TCK = 0;
	localparam int PIN_TMS = 1;
	localparam int PIN_TDI = 2;
	localparam int PIN_TDO = 3;
	localparam int PIN_TRST = 4;
	localparam int CODE_W = 16;
	localparam logic [CODE_W-1:0] CODE_TO_SWD = 16'hE79E;
	localparam logic [CODE_W-1:0] CODE_TO_JTAG = 16'hE73C;
	localparam int PRE_ONES = 50;
	localparam int SWD_POST_ONES = 50;
	localparam int JTAG_POST_ONES = 5;
	localparam int HIST_W = PRE_ONES + CODE_W;
	localparam int RUN_W = 7;
	localparam logic [RUN_W-1:0] RUN_MAX = 7'h7F;
	localparam logic [RUN_W-1:0] LINE_RESET_RUN = 7'h32;
	localparam int REC_W = 4;
	localparam logic [REC_W-1:0] RECOVER_SWITCHES = 4'hA;
	localparam int IR_W = 4;
	localparam logic [IR_W-1:0] IR_IDCODE = 4'hE;
	localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam int DR_W = 32;
	// Identification value is arbitrary; only its set least significant bit matters
	localparam logic [DR_W-1:0] ID_VALUE = 32'h1234_5671;
	localparam logic [DR_W-1:0] LOCK_KEY = 32'h600D_C0DE;
	localparam logic [NPIN-1:0] PINS_ON = 5'h1F;
	localparam int CLK_PERIOD_NS = 40;
	localparam int LINK_PERIOD_NS = 320;
	localparam int TCK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int DIV_W = 4;
	localparam int SEQ_W = 128;
	localparam int LEN_W = 8;

	typedef enum logic [3:0] {
		TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
		TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7,
		TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR = 4'hB,
		TAP_EX1_IR = 4'hC, TAP_PAU_IR = 4'hD, TAP_EX2_IR = 4'hE, TAP_UPD_IR = 4'hF
	} jsp_tap_e;

	typedef enum logic [1:0] {
		CFG_AFSEL = 2'h0,
		CFG_LOCK = 2'h1,
		CFG_COMMIT = 2'h2
	} jsp_cfg_e;

	typedef enum logic [1:0] {
		CMD_TO_SWD = 2'h0,
		CMD_TO_JTAG = 2'h1,
		CMD_RECOVER = 2'h2,
		CMD_RAW = 2'h3
	} jsp_cmd_e;

	typedef enum logic [1:0] {
		PRB_IDLE = 2'h0,
		PRB_RUN = 2'h1,
		PRB_DONE = 2'h2
	} jsp_prb_e;
endpackage

// *** verilog/jsp_link_if.sv ***
// Five shared debug pins plus the external reset line between probe and device.
// Each pin resolves from both drivers' enables; an undriven pin reads high (pull-up).
`timescale 1ns/100ps
interface jsp_link_if;
	logic [4:0] p_o;
	logic [4:0] p_oe;
	logic [4:0] d_o;
	logic [4:0] d_oe;
	logic ext_rst_n;
	logic [4:0] pin;

	for (genvar i = 0; i < 5; i++) begin : g_pin
		assign pin[i] = d_oe[i] ? d_o[i] : (p_oe[i] ? p_o[i] : 1'b1);
	end

	modport device (input pin, input ext_rst_n, output d_o, output d_oe);
	modport probe (input pin, output p_o, output p_oe, output ext_rst_n);
endinterface

// *** verilog/jsp_device.sv ***
// Device end: test access port, shift chains, protocol switch, pin muxing and recovery.
// Assumes the link pins arrive asynchronously and are sampled on clock_in.
// Operation
// - Capture states load selected chain in parallel
// - Shift states move TDI in, TDO out
// - Update states copy chain; hold otherwise
// - Resets restore debug function on all pins
// - Cleared alternate-function bits make pins GPIO
// - Alternate-function writes need unlock and commit
// - Ten alternating switches in reset erase flash
// - Probe holds reset through five switch pairs
// - Recovery switches may omit trailing ones
// - Switch walk enables serial-wire, disables scan
// - Code E79E selects serial-wire mode
// - Fifty ones framing; trailing run resets line
// - Code E73C selects boundary-scan mode
// - Fifty ones before, five after, ends reset
// - Software re-enables all five pins for debug
// - Test-logic-reset loads identification instruction
// - Five high TMS edges reach test-logic-reset
// - Test reset forces test-logic-reset while held
`timescale 1ns/100ps
module jsp_device
	import jsp_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	jsp_link_if.device link,
	input wire logic cfg_wr_in,
	input wire jsp_cfg_e cfg_sel_in,
	input wire logic [DR_W-1:0] cfg_wdata_in,
	input wire logic [NPIN-1:0] gpio_out_in,
	input wire logic [NPIN-1:0] gpio_oe_in,
	output logic [NPIN-1:0] gpio_in_out,
	output logic [NPIN-1:0] alt_function_select_out,
	output logic [NPIN-1:0] digital_enable_bits_out,
	output logic [NPIN-1:0] pull_up_select_out,
	output logic [NPIN-1:0] commit_mask_out,
	output logic unlocked_out,
	output logic swd_mode_out,
	output logic swd_line_reset_out,
	output logic mass_erase_out,
	output logic [IR_W-1:0] instruction_out,
	output logic [DR_W-1:0] dr_update_out
);
	typedef struct packed {
		logic [NPIN:0] sync1;
		logic [NPIN:0] sync2;
		logic tck_prev;
		jsp_tap_e tap;
		logic [IR_W-1:0] ir_sh;
		logic [IR_W-1:0] ir;
		logic [DR_W-1:0] dr_sh;
		logic [DR_W-1:0] dr_upd;
		logic tdo;
		logic tdo_oe;
		logic [HIST_W-1:0] hist;
		logic [RUN_W-1:0] ones;
		logic swd;
		logic line_reset;
		logic [REC_W-1:0] rec_cnt;
		logic erase;
		logic [NPIN-1:0] afsel;
		logic [NPIN-1:0] den;
		logic [NPIN-1:0] pur;
		logic [NPIN-1:0] commit;
		logic unlocked;
	} jsp_dev_s;

	jsp_dev_s st_q;
	jsp_dev_s st_d;

	function automatic jsp_tap_e tap_next(input jsp_tap_e s, input logic tms);
		case (s)
			TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			default: tap_next = TAP_RESET;
		endcase
	endfunction

	// True when the newest bits are a full run of ones followed by the code
	function automatic logic code_seen(input logic [HIST_W-1:0] h, input logic [CODE_W-1:0] code);
		code_seen = (&h[PRE_ONES-1:0]) && (h[HIST_W-1:PRE_ONES] == code);
	endfunction

	logic tck_lvl;
	logic tms;
	logic tdi;
	logic trst_n;
	logic ext_rst;
	logic rise;
	logic fall;
	logic to_swd;
	logic to_jtag;
	logic [NPIN-1:0] wr_ok;

	always_comb begin
		st_d = st_q;
		// Pins given over to GPIO look idle-high to the debug logic
		tck_lvl = st_q.afsel[PIN_TCK] ? st_q.sync2[PIN_TCK] : 1'b1;
		tms = st_q.afsel[PIN_TMS] ? st_q.sync2[PIN_TMS] : 1'b1;
		tdi = st_q.afsel[PIN_TDI] ? st_q.sync2[PIN_TDI] : 1'b1;
		trst_n = st_q.afsel[PIN_TRST] ? st_q.sync2[PIN_TRST] : 1'b1;
		ext_rst = ~st_q.sync2[NPIN];
		// No edges while the clock pin is GPIO, nor a rising one in the cycle it is handed back
		rise = st_q.afsel[PIN_TCK] & tck_lvl & ~st_q.tck_prev;
		fall = st_q.afsel[PIN_TCK] & ~tck_lvl & st_q.tck_prev;
		to_swd = 1'b0;
		to_jtag = 1'b0;
		wr_ok = st_q.commit & {NPIN{st_q.unlocked}};
		st_d.sync1 = {link.ext_rst_n, link.pin};
		st_d.sync2 = st_q.sync1;
		st_d.tck_prev = tck_lvl;
		st_d.line_reset = 1'b0;
		st_d.erase = 1'b0;

		if (rise) begin
			st_d.hist = {tms, st_q.hist[HIST_W-1:1]};
			st_d.ones = tms ? ((st_q.ones == RUN_MAX) ? RUN_MAX : st_q.ones + 1'b1) : '0;
			to_swd = code_seen(st_d.hist, CODE_TO_SWD);
			to_jtag = code_seen(st_d.hist, CODE_TO_JTAG);
			if (to_swd) begin
				st_d.swd = 1'b1;
			end else if (to_jtag) begin
				st_d.swd = 1'b0;
			end
			if (st_q.swd && tms && st_d.ones == LINE_RESET_RUN) begin
				st_d.line_reset = 1'b1;
			end
			// Recovery counts strictly alternating switches begun with serial-wire
			if (ext_rst && (to_swd || to_jtag)) begin
				if (to_swd == ~st_q.rec_cnt[0]) begin
					st_d.rec_cnt = st_q.rec_cnt + 1'b1;
				end else begin
					st_d.rec_cnt = to_swd ? 4'h1 : 4'h0;
				end
				if (st_d.rec_cnt == RECOVER_SWITCHES) begin
					st_d.erase = 1'b1;
					st_d.rec_cnt = '0;
				end
			end
			if (!st_q.swd) begin
				case (st_q.tap)
					TAP_CAP_DR: st_d.dr_sh = (st_q.ir == IR_IDCODE) ? ID_VALUE : '0;
					TAP_SH_DR: begin
						if (st_q.ir == IR_IDCODE) begin
							st_d.dr_sh = {tdi, st_q.dr_sh[DR_W-1:1]};
						end else begin
							st_d.dr_sh = {st_q.dr_sh[DR_W-1:1], tdi};
						end
					end
					TAP_UPD_DR: st_d.dr_upd = st_q.dr_sh;
					TAP_CAP_IR: st_d.ir_sh = IR_CAPTURE;
					TAP_SH_IR: st_d.ir_sh = {tdi, st_q.ir_sh[IR_W-1:1]};
					TAP_UPD_IR: st_d.ir = st_q.ir_sh;
					default: st_d.ir = st_q.ir;
				endcase
				st_d.tap = tap_next(st_q.tap, tms);
				if (st_d.tap == TAP_RESET) begin
					st_d.ir = IR_IDCODE;
				end
			end
		end

		// Output data changes on the falling link edge so the probe samples it stable
		if (fall) begin
			st_d.tdo_oe = !st_q.swd && (st_q.tap == TAP_SH_DR || st_q.tap == TAP_SH_IR);
			if (st_q.tap == TAP_SH_IR) begin
				st_d.tdo = st_q.ir_sh[0];
			end else if (st_q.tap == TAP_SH_DR) begin
				st_d.tdo = st_q.dr_sh[0];
			end
		end

		if (!trst_n) begin
			st_d.tap = TAP_RESET;
			st_d.ir = IR_IDCODE;
			st_d.tdo_oe = 1'b0;
			st_d.swd = 1'b0;
			st_d.line_reset = 1'b0;
		end
		if (!ext_rst) begin
			st_d.rec_cnt = '0;
		end

		if (cfg_wr_in) begin
			case (cfg_sel_in)
				CFG_AFSEL: st_d.afsel = (st_q.afsel & ~wr_ok) | (cfg_wdata_in[NPIN-1:0] & wr_ok);
				CFG_LOCK: st_d.unlocked = (cfg_wdata_in == LOCK_KEY);
				CFG_COMMIT: begin
					if (st_q.unlocked) begin
						st_d.commit = cfg_wdata_in[NPIN-1:0];
					end
				end
				default: st_d.unlocked = st_q.unlocked;
			endcase
		end
		if (ext_rst) begin
			st_d.afsel = PINS_ON;
			st_d.den = PINS_ON;
			st_d.pur = PINS_ON;
			st_d.commit = '0;
			st_d.unlocked = 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
			st_q.sync1 <= '1;
			st_q.sync2 <= '1;
			st_q.tck_prev <= 1'b1;
			st_q.tap <= TAP_RESET;
			st_q.ir <= IR_IDCODE;
			st_q.afsel <= PINS_ON;
			st_q.den <= PINS_ON;
			st_q.pur <= PINS_ON;
		end else begin
			st_q <= st_d;
		end
	end

	// Debug function drives only the data-out pin; GPIO owns any pin released to it
	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			if (st_q.afsel[i]) begin
				link.d_o[i] = (i == PIN_TDO) ? st_q.tdo : 1'b0;
				link.d_oe[i] = (i == PIN_TDO) ? st_q.tdo_oe : 1'b0;
			end else begin
				link.d_o[i] = gpio_out_in[i];
				link.d_oe[i] = gpio_oe_in[i];
			end
		end
	end

	assign gpio_in_out = st_q.sync2[NPIN-1:0];
	assign alt_function_select_out = st_q.afsel;
	assign digital_enable_bits_out = st_q.den;
	assign pull_up_select_out = st_q.pur;
	assign commit_mask_out = st_q.commit;
	assign unlocked_out = st_q.unlocked;
	assign swd_mode_out = st_q.swd;
	assign swd_line_reset_out = st_q.line_reset;
	assign mass_erase_out = st_q.erase;
	assign instruction_out = st_q.ir;
	assign dr_update_out = st_q.dr_upd;
endmodule

// *** verilog/jsp_probe.sv ***
// Probe end: makes the link clock by division and plays bit sequences on TMS and TDI.
// Assumes the device samples TMS/TDI on the rising link edge and updates TDO on the falling one.
`timescale 1ns/100ps
module jsp_probe
	import jsp_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	jsp_link_if.probe link,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire jsp_cmd_e cmd_in,
	input wire logic [SEQ_W-1:0] raw_tms_in,
	input wire logic [SEQ_W-1:0] raw_tdi_in,
	input wire logic [LEN_W-1:0] raw_len_in,
	input wire logic trst_n_in,
	output logic [SEQ_W-1:0] cap_tdo_out,
	output logic done_out,
	output logic recovering_out
);
	typedef struct packed {
		jsp_prb_e st;
		logic tck;
		logic [DIV_W-1:0] div;
		logic [SEQ_W-1:0] tms_v;
		logic [SEQ_W-1:0] tdi_v;
		logic [LEN_W-1:0] left;
		logic [SEQ_W-1:0] cap;
		logic recover;
		logic [REC_W-1:0] rec_n;
		logic ext_rst_n;
		logic done;
	} jsp_prb_s;

	jsp_prb_s st_q;
	jsp_prb_s st_d;

	// Leading ones, then the code least significant bit first, then ones
	function automatic logic [SEQ_W-1:0] sw_vec(input logic [CODE_W-1:0] code);
		sw_vec = '1;
		sw_vec[PRE_ONES +: CODE_W] = code;
	endfunction

	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		case (st_q.st)
			PRB_IDLE: begin
				st_d.tck = 1'b0;
				st_d.div = '0;
				if (cmd_valid_in) begin
					st_d.st = PRB_RUN;
					st_d.recover = 1'b0;
					st_d.tdi_v = '1;
					case (cmd_in)
						CMD_TO_SWD: begin
							st_d.tms_v = sw_vec(CODE_TO_SWD);
							st_d.left = LEN_W'(HIST_W + SWD_POST_ONES);
						end
						CMD_TO_JTAG: begin
							st_d.tms_v = sw_vec(CODE_TO_JTAG);
							st_d.left = LEN_W'(HIST_W + JTAG_POST_ONES);
						end
						CMD_RECOVER: begin
							st_d.recover = 1'b1;
							st_d.rec_n = '0;
							st_d.ext_rst_n = 1'b0;
							st_d.tms_v = sw_vec(CODE_TO_SWD);
							st_d.left = LEN_W'(HIST_W);
						end
						default: begin
							st_d.tms_v = raw_tms_in;
							st_d.tdi_v = raw_tdi_in;
							st_d.left = raw_len_in;
							if (raw_len_in == '0) begin
								st_d.st = PRB_DONE;
							end
						end
					endcase
				end
			end
			PRB_RUN: begin
				if (st_q.div == DIV_W'(TCK_HALF_CYC - 1)) begin
					st_d.div = '0;
					st_d.tck = ~st_q.tck;
					if (!st_q.tck) begin
						st_d.cap = {link.pin[PIN_TDO], st_q.cap[SEQ_W-1:1]};
					end else begin
						st_d.tms_v = {1'b1, st_q.tms_v[SEQ_W-1:1]};
						st_d.tdi_v = {1'b1, st_q.tdi_v[SEQ_W-1:1]};
						st_d.left = st_q.left - 1'b1;
						if (st_q.left == LEN_W'(1)) begin
							st_d.st = PRB_DONE;
							// Recovery alternates the two codes until ten switches are sent
							if (st_q.recover && st_q.rec_n != RECOVER_SWITCHES - 1'b1) begin
								st_d.st = PRB_RUN;
								st_d.rec_n = st_q.rec_n + 1'b1;
								st_d.tms_v = sw_vec(st_q.rec_n[0] ? CODE_TO_SWD : CODE_TO_JTAG);
								st_d.left = LEN_W'(HIST_W);
							end
						end
					end
				end else begin
					st_d.div = st_q.div + 1'b1;
				end
			end
			PRB_DONE: begin
				st_d.ext_rst_n = 1'b1;
				st_d.done = 1'b1;
				st_d.st = PRB_IDLE;
			end
			default: st_d.st = PRB_IDLE;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
			st_q.st <= PRB_IDLE;
			st_q.tms_v <= '1;
			st_q.tdi_v <= '1;
			st_q.ext_rst_n <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	always_comb begin
		link.p_o = '0;
		link.p_oe = '1;
		link.p_oe[PIN_TDO] = 1'b0;
		link.p_o[PIN_TCK] = st_q.tck;
		link.p_o[PIN_TMS] = st_q.tms_v[0];
		link.p_o[PIN_TDI] = st_q.tdi_v[0];
		link.p_o[PIN_TRST] = trst_n_in;
	end

	assign link.ext_rst_n = st_q.ext_rst_n;
	assign cmd_ready_out = (st_q.st == PRB_IDLE);
	assign cap_tdo_out = st_q.cap;
	assign done_out = st_q.done;
	assign recovering_out = st_q.recover && (st_q.st == PRB_RUN);
endmodule

// *** verif/jsp_props.sv ***
// Concurrent checks on the link pins and the device's configuration outputs.
// Assumes one clock domain and the synchronous active-low reset rst_n_in.
`timescale 1ns/100ps
module jsp_props
	import jsp_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [4:0] pin,
	input wire logic ext_rst_n,
	input wire logic cfg_wr_in,
	input wire jsp_cfg_e cfg_sel_in,
	input wire logic [DR_W-1:0] cfg_wdata_in,
	input wire logic [NPIN-1:0] alt_function_select_out,
	input wire logic [NPIN-1:0] digital_enable_bits_out,
	input wire logic [NPIN-1:0] pull_up_select_out,
	input wire logic [NPIN-1:0] commit_mask_out,
	input wire logic unlocked_out,
	input wire logic swd_mode_out,
	input wire logic swd_line_reset_out,
	input wire logic mass_erase_out,
	input wire logic [IR_W-1:0] instruction_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	a_ext_rst_pins: assert property (!ext_rst_n [*5] |-> alt_function_select_out == PINS_ON
		&& digital_enable_bits_out == PINS_ON && pull_up_select_out == PINS_ON
		&& commit_mask_out == '0 && !unlocked_out) else $error("pins not restored by reset");
	a_afsel_guard: assert property (cfg_wr_in && cfg_sel_in == CFG_AFSEL |=>
		($past(alt_function_select_out) & ~alt_function_select_out
		& ~($past(commit_mask_out) & {NPIN{$past(unlocked_out)}})) == '0) else $error("protected bit cleared");
	a_afsel_write: assert property (ext_rst_n [*6] ##0 cfg_wr_in && cfg_sel_in == CFG_AFSEL
		&& unlocked_out && commit_mask_out == PINS_ON |=>
		alt_function_select_out == $past(cfg_wdata_in[NPIN-1:0])) else $error("select write lost");
	a_unlock_key: assert property (ext_rst_n [*6] ##0 cfg_wr_in && cfg_sel_in == CFG_LOCK |=>
		unlocked_out == ($past(cfg_wdata_in) == LOCK_KEY)) else $error("lock state wrong");
	a_trst_flag: assert property ((!pin[PIN_TRST] && alt_function_select_out[PIN_TRST]) [*5] |-> !swd_mode_out)
		else $error("flag set under test reset");
	a_trst_instr: assert property ((!pin[PIN_TRST] && alt_function_select_out[PIN_TRST]) [*5] |->
		instruction_out == IR_IDCODE)
		else $error("instruction not default under test reset");
	a_flag_quiet: assert property (!pin[PIN_TCK] [*8] |=> !$rose(swd_mode_out))
		else $error("flag rose without link clock");
	a_erase_pulse: assert property (mass_erase_out |-> !$past(ext_rst_n, 4) ##1 !mass_erase_out [*8])
		else $error("erase outside held reset");
	a_line_reset: assert property (swd_line_reset_out |-> swd_mode_out)
		else $error("line reset outside serial-wire mode");

	c_swd: cover property ($rose(swd_mode_out));
	c_erase: cover property (mass_erase_out);
	c_line: cover property (swd_line_reset_out);
endmodule

// *** verif/jtag_swd_port_switch_tb.sv ***
// Self-checking bench: probe and device joined by the link, driven by probe commands and config writes.
// Assumes a 25 MHz clock and a synchronous active-low reset held for 16 cycles.
`timescale 1ns/100ps
module jtag_swd_port_switch_tb;
	import jsp_pkg::*;
	logic clock_in = 0;
	logic rst_n_in = 0;
	logic cfg_wr_in = 0;
	jsp_cfg_e cfg_sel_in = CFG_AFSEL;
	logic [DR_W-1:0] cfg_wdata_in = '0;
	logic [NPIN-1:0] gpio_out_in = '0;
	logic [NPIN-1:0] gpio_oe_in = '0;
	logic [NPIN-1:0] gpio_in_out, alt_function_select_out, digital_enable_bits_out;
	logic [NPIN-1:0] pull_up_select_out, commit_mask_out;
	logic unlocked_out, swd_mode_out, swd_line_reset_out, mass_erase_out;
	logic cmd_ready_out, done_out, recovering_out;
	logic [IR_W-1:0] instruction_out;
	logic [DR_W-1:0] dr_update_out;
	logic cmd_valid_in = 0;
	jsp_cmd_e cmd_in = CMD_RAW;
	logic [SEQ_W-1:0] raw_tms_in = '0;
	logic [SEQ_W-1:0] raw_tdi_in = '0;
	logic [SEQ_W-1:0] cap_tdo_out;
	logic [LEN_W-1:0] raw_len_in = '0;
	logic trst_n_in = 1;
	int n_errors = 0;
	int cmp_count = 0;
	int n_erase = 0;
	int n_lres = 0;
	localparam logic [DR_W-1:0] DR_PAT = 32'hA5C3_0F96;

	jsp_link_if link();
	jsp_device jsp_device_inst(.*);
	jsp_probe jsp_probe_inst(.*);
	jsp_props jsp_props_inst(.clock_in, .rst_n_in, .pin(link.pin), .ext_rst_n(link.ext_rst_n), .cfg_wr_in,
		.cfg_sel_in, .cfg_wdata_in, .alt_function_select_out, .digital_enable_bits_out, .pull_up_select_out,
		.commit_mask_out, .unlocked_out, .swd_mode_out, .swd_line_reset_out, .mass_erase_out, .instruction_out);

	always #(CLK_PERIOD_NS / 2) clock_in = ~clock_in;

	always @(posedge clock_in) begin
		n_erase <= n_erase + (mass_erase_out === 1'b1);
		n_lres <= n_lres + (swd_line_reset_out === 1'b1);
	end

	task automatic chk(input logic [SEQ_W-1:0] seen, input logic [SEQ_W-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cfg(input jsp_cfg_e sel, input logic [DR_W-1:0] data);
		cfg_sel_in <= sel;
		cfg_wdata_in <= data;
		cfg_wr_in <= 1'b1;
		@(posedge clock_in);
		cfg_wr_in <= 1'b0;
		@(posedge clock_in);
	endtask

	task automatic run(input jsp_cmd_e c, input logic [SEQ_W-1:0] tms, input logic [SEQ_W-1:0] tdi, input int n);
		int k = 0;
		cmd_in <= c;
		raw_tms_in <= tms;
		raw_tdi_in <= tdi;
		raw_len_in <= LEN_W'(n);
		cmd_valid_in <= 1'b1;
		// Ready and done are looked at mid-cycle, where they are settled
		@(negedge clock_in);
		while (cmd_ready_out !== 1'b1) @(negedge clock_in);
		@(posedge clock_in);
		cmd_valid_in <= 1'b0;
		do @(negedge clock_in); while (done_out !== 1'b1 && ++k < 8000);
		chk(k < 8000, 1'b1);
		// Let the device's pin synchronisers settle
		repeat (8) @(posedge clock_in);
	endtask

	task automatic end_sim;
		if (n_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#(CLK_PERIOD_NS * 40000);
		n_errors++;
		end_sim;
	end

	initial begin
		repeat (16) @(posedge clock_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clock_in);
		chk(alt_function_select_out, PINS_ON);
		chk(digital_enable_bits_out, PINS_ON);
		chk(pull_up_select_out, PINS_ON);
		chk(swd_mode_out, 1'b0);
		chk(instruction_out, IR_IDCODE);
		// Data scan of the identification chain, new pattern in, then update
		run(CMD_RAW, (128'h3 << 35) | 128'h2, {96'h0, DR_PAT} << 4, 38);
		chk(cap_tdo_out[125:94], ID_VALUE);
		chk(dr_update_out, DR_PAT);
		run(CMD_RAW, 128'h183, 128'hF0, 10);
		chk(cap_tdo_out[125:122], IR_CAPTURE);
		chk(instruction_out, IR_BYPASS);
		chk(dr_update_out, DR_PAT);
		run(CMD_RAW, 128'h1F, '1, 5);
		chk(instruction_out, IR_IDCODE);
		// Switch code sent in the wrong bit order
		run(CMD_RAW, {62'h0, 16'h79E7, {50{1'b1}}}, '1, 66);
		chk(swd_mode_out, 1'b0);
		run(CMD_TO_SWD, '0, '1, 0);
		chk(swd_mode_out, 1'b1);
		chk(n_lres, 1);
		run(CMD_RAW, 128'h306, 128'h1E0, 11);
		chk(instruction_out, IR_IDCODE);
		run(CMD_TO_JTAG, '0, '1, 0);
		chk(swd_mode_out, 1'b0);
		run(CMD_RAW, 128'h306, 128'h1E0, 11);
		chk(instruction_out, IR_BYPASS);
		run(CMD_TO_SWD, '0, '1, 0);
		trst_n_in <= 1'b0;
		repeat (8) @(posedge clock_in);
		chk(swd_mode_out, 1'b0);
		chk(instruction_out, IR_IDCODE);
		trst_n_in <= 1'b1;
		// Commit protection on the alternate-function bits
		cfg(CFG_LOCK, 32'h0000_0001);
		cfg(CFG_AFSEL, '0);
		chk(alt_function_select_out, PINS_ON);
		chk(unlocked_out, 1'b0);
		cfg(CFG_LOCK, LOCK_KEY);
		cfg(CFG_AFSEL, '0);
		chk(alt_function_select_out, PINS_ON);
		cfg(CFG_COMMIT, 32'h0000_0003);
		cfg(CFG_AFSEL, '0);
		chk(alt_function_select_out, 5'h1C);
		cfg(CFG_COMMIT, PINS_ON);
		cfg(CFG_AFSEL, '0);
		chk(alt_function_select_out, '0);
		gpio_oe_in <= PINS_ON;
		for (int i = 0; i < 2; i++) begin
			gpio_out_in <= i ? 5'h15 : 5'h0A;
			repeat (6) @(posedge clock_in);
			chk(gpio_in_out, i ? 5'h15 : 5'h0A);
		end
		run(CMD_TO_SWD, '0, '1, 0);
		chk(swd_mode_out, 1'b0);
		gpio_oe_in <= '0;
		cfg(CFG_AFSEL, 32'h0000_000F);
		run(CMD_RECOVER, '0, '1, 0);
		chk(n_erase, 1);
		chk(alt_function_select_out, PINS_ON);
		chk(commit_mask_out, '0);
		chk(unlocked_out, 1'b0);
		chk(recovering_out, 1'b0);
		chk(swd_mode_out, 1'b0);
		end_sim;
	end
endmodule
